// ===== inc/gpk_map.vh
`ifndef GPK_MAP_VH
`define GPK_MAP_VH
`define GPK_A_DATA 8'h00
`define GPK_B_DATA 8'h01
`define GPK_A_DIR 8'h02
`define GPK_B_DIR 8'h03
`define GPK_E_DATA 8'h08
`define GPK_E_DIR 8'h09
`define GPK_E_ASSIGN 8'h0a
`define GPK_PULL_CTL 8'h0c
`define GPK_DRIVE_CTL 8'h0d
`define GPK_G_DATA 8'h10
`define GPK_G_DIR 8'h11
`define GPK_G_WIE 8'h12
`define GPK_G_WFLG 8'h13
`define GPK_H_DATA 8'h14
`define GPK_H_DIR 8'h15
`define GPK_H_WIE 8'h16
`define GPK_H_WFLG 8'h17
`define GPK_PULL_A_BIT 0
`define GPK_PULL_B_BIT 1
`define GPK_PULL_E_BIT 4
`define GPK_PULL_G_BIT 5
`define GPK_PULL_H_BIT 6
`define GPK_RD_A_BIT 0
`define GPK_RD_B_BIT 1
`define GPK_RD_E_BIT 4
`define GPK_RD_G_BIT 5
`define GPK_RD_H_BIT 6
`define GPK_PULL_RST 8'h10
`define GPK_ASSIGN_RST 8'h00
`define GPK_E_PULL_MASK 8'h8f
`define GPK_MODE_SINGLE 2'h0
`define GPK_MODE_EXPANDED 2'h1
`define GPK_MODE_PERIPH 2'h2
`endif

// ===== rtl/gpk_wake.v
`timescale 1ns/100ps
`include "gpk_map.vh"
module gpk_wake (
  input wire clk,
  input wire rst_n,
  input wire [7:0] pin_sync,
  input wire [7:0] wie_wr,
  input wire [7:0] clr_mask,
  input wire wie_we,
  output reg [7:0] flag_reg,
  output reg [7:0] wie_reg,
  output reg irq_reg
);
  reg [7:0] prev_reg;
  wire [7:0] fall;
  wire [7:0] flag_next;
  assign fall = prev_reg & ~pin_sync;
  assign flag_next = (flag_reg & ~clr_mask) | fall;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_reg <= 8'hff;
      flag_reg <= 8'h00;
      wie_reg <= 8'h00;
      irq_reg <= 1'b0;
    end else begin
      prev_reg <= pin_sync;
      flag_reg <= flag_next;
      if (wie_we) begin
        wie_reg <= wie_wr;
      end
      irq_reg <= |(flag_next & (wie_we ? wie_wr : wie_reg));
    end
  end
endmodule

// ===== rtl/gpk_ports.v
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`include "gpk_map.vh"
module gpk_ports (
  input wire clk,
  input wire rst_n,
  input wire [1:0] op_mode,
  input wire port_e_emulation_select,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  input wire [7:0] pa_in,
  output reg [7:0] pa_out,
  output reg [7:0] pa_oe_n,
  output reg [7:0] pa_pullup,
  input wire [7:0] pb_in,
  output reg [7:0] pb_out,
  output reg [7:0] pb_oe_n,
  output reg [7:0] pb_pullup,
  input wire [7:0] pe_in,
  output reg [7:0] pe_out,
  output reg [7:0] pe_oe_n,
  output reg [7:0] pe_pullup,
  output reg [7:0] pe_assign,
  input wire [7:0] pg_in,
  output reg [7:0] pg_out,
  output reg [7:0] pg_oe_n,
  output reg [7:0] pg_pullup,
  output reg [7:0] pg_pulldown,
  input wire port_g_pull_polarity_pin,
  input wire [7:0] ph_in,
  output reg [7:0] ph_out,
  output reg [7:0] ph_oe_n,
  output reg [7:0] ph_pullup,
  output reg [7:0] ph_pulldown,
  input wire port_h_pull_polarity_pin,
  output reg [7:0] drive_reduce,
  output wire port_g_wake_irq,
  output wire port_h_wake_irq,
  output reg maskable_irq_pin,
  output reg nonmaskable_irq_input
);
  reg [7:0] a_data_reg;
  reg [7:0] b_data_reg;
  reg [7:0] e_data_reg;
  reg [7:0] g_data_reg;
  reg [7:0] h_data_reg;
  reg [7:0] port_a_direction, port_b_direction, port_e_direction;
  reg [7:0] port_g_direction, port_h_direction;
  reg [7:0] port_e_pin_assignment;
  reg [7:0] pull_enable_control;
  reg [7:0] drive_reduce_control;
  reg drive_written_reg;
  reg [7:0] pa_s1;
  reg [7:0] pa_s2;
  reg [7:0] pb_s1;
  reg [7:0] pb_s2;
  reg [7:0] pe_s1;
  reg [7:0] pe_s2;
  reg [7:0] pg_s1;
  reg [7:0] pg_s2;
  reg [7:0] ph_s1;
  reg [7:0] ph_s2;
  reg [1:0] pol_s1, pol_s2;
  reg [7:0] rdata_next;
  wire periph;
  wire expanded;
  wire ab_mapped;
  wire e_mapped;
  wire drv_mapped;
  wire [7:0] g_flag, h_flag, g_wie, h_wie;
  wire [7:0] pe_dir_eff;
  wire [7:0] a_dir_eff, b_dir_eff;
  wire [7:0] g_clr_mask;
  wire [7:0] h_clr_mask;
  wire g_wie_we;
  wire h_wie_we;
  assign periph = (op_mode == `GPK_MODE_PERIPH);
  assign expanded = (op_mode == `GPK_MODE_EXPANDED);
  assign ab_mapped = !periph && !expanded;
  assign e_mapped = !periph && !(expanded && port_e_emulation_select);
  assign drv_mapped = !periph;
  assign a_dir_eff = expanded ? 8'h00 : port_a_direction;
  assign b_dir_eff = expanded ? 8'h00 : port_b_direction;
  // Assigned pins drive from bus logic; pins 1..0 never output
  assign pe_dir_eff = port_e_direction & ~port_e_pin_assignment & 8'hfc;
  // Flags clear on written ones
  assign g_clr_mask = (wr && addr == `GPK_G_WFLG) ? wdata : 8'h00;
  assign h_clr_mask = (wr && addr == `GPK_H_WFLG) ? wdata : 8'h00;
  assign g_wie_we = wr && (addr == `GPK_G_WIE);
  assign h_wie_we = wr && (addr == `GPK_H_WIE);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pa_s1 <= 8'h00;
      pa_s2 <= 8'h00;
      pb_s1 <= 8'h00;
      pb_s2 <= 8'h00;
      pe_s1 <= 8'hff;
      pe_s2 <= 8'hff;
      pg_s1 <= 8'hff;
      pg_s2 <= 8'hff;
      ph_s1 <= 8'hff;
      ph_s2 <= 8'hff;
      pol_s1 <= 2'h0;
      pol_s2 <= 2'h0;
    end else begin
      pa_s1 <= pa_in;
      pa_s2 <= pa_s1;
      pb_s1 <= pb_in;
      pb_s2 <= pb_s1;
      pe_s1 <= pe_in;
      pe_s2 <= pe_s1;
      pg_s1 <= pg_in;
      pg_s2 <= pg_s1;
      ph_s1 <= ph_in;
      ph_s2 <= ph_s1;
      pol_s1 <= {port_h_pull_polarity_pin, port_g_pull_polarity_pin};
      pol_s2 <= pol_s1;
    end
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      a_data_reg <= 8'h00;
      b_data_reg <= 8'h00;
      e_data_reg <= 8'h00;
      g_data_reg <= 8'h00;
      h_data_reg <= 8'h00;
      port_a_direction <= 8'h00;
      port_b_direction <= 8'h00;
      port_e_direction <= 8'h00;
      port_g_direction <= 8'h00;
      port_h_direction <= 8'h00;
      port_e_pin_assignment <= `GPK_ASSIGN_RST;
      pull_enable_control <= `GPK_PULL_RST;
      drive_reduce_control <= 8'h00;
      drive_written_reg <= 1'b0;
    end else if (wr) begin
      case (addr)
        `GPK_A_DATA: begin
          if (ab_mapped) begin
            a_data_reg <= wdata;
          end
        end
        `GPK_B_DATA: begin
          if (ab_mapped) begin
            b_data_reg <= wdata;
          end
        end
        `GPK_A_DIR: begin
          if (ab_mapped) begin
            port_a_direction <= wdata;
          end
        end
        `GPK_B_DIR: begin
          if (ab_mapped) begin
            port_b_direction <= wdata;
          end
        end
        `GPK_E_DATA: begin
          if (e_mapped) begin
            e_data_reg <= wdata;
          end
        end
        `GPK_E_DIR: begin
          if (e_mapped) begin
            port_e_direction <= wdata;
          end
        end
        `GPK_E_ASSIGN: begin
          port_e_pin_assignment <= wdata;
        end
        `GPK_PULL_CTL: begin
          pull_enable_control <= wdata;
        end
        `GPK_DRIVE_CTL: begin
          if (drv_mapped && !drive_written_reg) begin
            drive_reduce_control <= wdata;
            drive_written_reg <= 1'b1;
          end
        end
        `GPK_G_DATA: begin
          g_data_reg <= wdata;
        end
        `GPK_G_DIR: begin
          port_g_direction <= wdata;
        end
        `GPK_H_DATA: begin
          h_data_reg <= wdata;
        end
        `GPK_H_DIR: begin
          port_h_direction <= wdata;
        end
        default: ;
      endcase
    end
  end
  gpk_wake u_wake_g (
    .clk(clk),
    .rst_n(rst_n),
    .pin_sync(pg_s2),
    .wie_wr(wdata),
    .clr_mask(g_clr_mask),
    .wie_we(g_wie_we),
    .flag_reg(g_flag),
    .wie_reg(g_wie),
    .irq_reg(port_g_wake_irq)
  );
  gpk_wake u_wake_h (
    .clk(clk),
    .rst_n(rst_n),
    .pin_sync(ph_s2),
    .wie_wr(wdata),
    .clr_mask(h_clr_mask),
    .wie_we(h_wie_we),
    .flag_reg(h_flag),
    .wie_reg(h_wie),
    .irq_reg(port_h_wake_irq)
  );
  // Reads: pin level for inputs, latch for outputs
  always @* begin
    rdata_next = 8'h00;
    case (addr)
      `GPK_A_DATA: begin
        if (ab_mapped) begin
          rdata_next = (a_data_reg & port_a_direction) | (pa_s2 & ~port_a_direction);
        end
      end
      `GPK_B_DATA: begin
        if (ab_mapped) begin
          rdata_next = (b_data_reg & port_b_direction) | (pb_s2 & ~port_b_direction);
        end
      end
      `GPK_A_DIR: begin
        if (ab_mapped) begin
          rdata_next = port_a_direction;
        end
      end
      `GPK_B_DIR: begin
        if (ab_mapped) begin
          rdata_next = port_b_direction;
        end
      end
      `GPK_E_DATA: begin
        if (e_mapped) begin
          rdata_next = (e_data_reg & pe_dir_eff) | (pe_s2 & ~pe_dir_eff);
        end
      end
      `GPK_E_DIR: begin
        if (e_mapped) begin
          rdata_next = port_e_direction;
        end
      end
      `GPK_E_ASSIGN: begin
        rdata_next = port_e_pin_assignment;
      end
      `GPK_PULL_CTL: begin
        rdata_next = pull_enable_control;
      end
      `GPK_DRIVE_CTL: begin
        if (drv_mapped) begin
          rdata_next = drive_reduce_control;
        end
      end
      `GPK_G_DATA: begin
        rdata_next = (g_data_reg & port_g_direction) | (pg_s2 & ~port_g_direction);
      end
      `GPK_G_DIR: begin
        rdata_next = port_g_direction;
      end
      `GPK_G_WIE: begin
        rdata_next = g_wie;
      end
      `GPK_G_WFLG: begin
        rdata_next = g_flag;
      end
      `GPK_H_DATA: begin
        rdata_next = (h_data_reg & port_h_direction) | (ph_s2 & ~port_h_direction);
      end
      `GPK_H_DIR: begin
        rdata_next = port_h_direction;
      end
      `GPK_H_WIE: begin
        rdata_next = h_wie;
      end
      `GPK_H_WFLG: begin
        rdata_next = h_flag;
      end
      default: rdata_next = 8'h00;
    endcase
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
      pa_out <= 8'h00;
      pa_oe_n <= 8'hff;
      pa_pullup <= 8'h00;
      pb_out <= 8'h00;
      pb_oe_n <= 8'hff;
      pb_pullup <= 8'h00;
      pe_out <= 8'h00;
      pe_oe_n <= 8'hff;
      pe_pullup <= 8'h00;
      pe_assign <= 8'h00;
      pg_out <= 8'h00;
      pg_oe_n <= 8'hff;
      pg_pullup <= 8'h00;
      pg_pulldown <= 8'h00;
      ph_out <= 8'h00;
      ph_oe_n <= 8'hff;
      ph_pullup <= 8'h00;
      ph_pulldown <= 8'h00;
      drive_reduce <= 8'h00;
      maskable_irq_pin <= 1'b1;
      nonmaskable_irq_input <= 1'b1;
    end else begin
      rdata <= rd ? rdata_next : 8'h00;
      pa_out <= a_data_reg;
      pa_oe_n <= ~a_dir_eff;
      pb_out <= b_data_reg;
      pb_oe_n <= ~b_dir_eff;
      pa_pullup <= (pull_enable_control[`GPK_PULL_A_BIT] && !expanded) ?
        ~a_dir_eff : 8'h00;
      pb_pullup <= (pull_enable_control[`GPK_PULL_B_BIT] && !expanded) ?
        ~b_dir_eff : 8'h00;
      pe_out <= e_data_reg;
      pe_oe_n <= ~pe_dir_eff;
      pe_assign <= port_e_pin_assignment;
      pe_pullup <= pull_enable_control[`GPK_PULL_E_BIT] ?
        (`GPK_E_PULL_MASK & ~pe_dir_eff) : 8'h00;
      pg_out <= g_data_reg;
      pg_oe_n <= ~port_g_direction;
      pg_pullup <= (pull_enable_control[`GPK_PULL_G_BIT] && pol_s2[0]) ?
        ~port_g_direction : 8'h00;
      pg_pulldown <= (pull_enable_control[`GPK_PULL_G_BIT] && !pol_s2[0]) ?
        ~port_g_direction : 8'h00;
      ph_out <= h_data_reg;
      ph_oe_n <= ~port_h_direction;
      ph_pullup <= (pull_enable_control[`GPK_PULL_H_BIT] && pol_s2[1]) ?
        ~port_h_direction : 8'h00;
      ph_pulldown <= (pull_enable_control[`GPK_PULL_H_BIT] && !pol_s2[1]) ?
        ~port_h_direction : 8'h00;
      // Port-wide reduced drive level
      drive_reduce <= drive_reduce_control;
      maskable_irq_pin <= pe_s2[1];
      nonmaskable_irq_input <= pe_s2[0];
    end
  end
endmodule

// ===== sim/gpk_pins.sv
`timescale 1ns/100ps
module gpk_pins (
  input wire [7:0] out,
  input wire [7:0] oe_n,
  input wire [7:0] ext,
  output wire [7:0] pin
);
  // Driven bits show the port, released bits the attached device
  assign pin = (out & ~oe_n) | (ext & oe_n);
endmodule

// ===== sim/gpk_ports_sva.sv
`timescale 1ns/100ps
`include "gpk_map.vh"
module gpk_ports_sva (
  input wire clk,
  input wire rst_n,
  input wire [1:0] op_mode,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  input wire [7:0] rdata,
  input wire [7:0] pa_oe_n,
  input wire [7:0] pb_oe_n,
  input wire [7:0] pe_oe_n,
  input wire [7:0] pg_oe_n,
  input wire [7:0] ph_oe_n,
  input wire [7:0] pa_pullup,
  input wire [7:0] pb_pullup,
  input wire [7:0] pe_pullup,
  input wire [7:0] pg_pullup,
  input wire [7:0] pg_pulldown,
  input wire [7:0] pe_assign,
  input wire [7:0] drive_reduce
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence a_dir_wr;
    wr && addr == `GPK_A_DIR && op_mode == `GPK_MODE_SINGLE ##1 !wr;
  endsequence
  sequence a_dir_hid;
    wr && addr == `GPK_A_DIR && op_mode == `GPK_MODE_PERIPH;
  endsequence
  reset_dirs_a: assert property (
    $rose(rst_n) |-> &{pa_oe_n, pb_oe_n, pe_oe_n, pg_oe_n, ph_oe_n})
    else $error("pin driven after reset");
  a_dir_write_a: assert property (
    a_dir_wr |=> pa_oe_n == ~$past(wdata, 2))
    else $error("port a direction wrong");
  a_dir_hidden_a: assert property (
    a_dir_hid |=> ##1 $stable(pa_oe_n))
    else $error("hidden direction written");
  rdata_idle_a: assert property (
    !rd || addr > 8'h17 |=> rdata == 8'h00)
    else $error("read data not zero");
  pe_input_only_a: assert property (
    $stable(pe_assign) [*2] |-> pe_oe_n[1:0] == 2'b11 && (pe_assign & ~pe_oe_n) == 8'h00)
    else $error("port e pin driven");
  pe_pull_mask_a: assert property (
    (pe_pullup & 8'h70) == 8'h00)
    else $error("port e pull on wrong pin");
  g_pull_kind_a: assert property (
    ((pg_pullup | pg_pulldown) & ~pg_oe_n | pg_pullup & pg_pulldown) == 8'h00)
    else $error("port g pull wrong");
  exp_no_pull_a: assert property (
    (op_mode == `GPK_MODE_EXPANDED) [*3] |-> (pa_pullup | pb_pullup) == 8'h00)
    else $error("bus port pulled");
  rdrv_lock_a: assert property (
    drive_reduce != 8'h00 |=> $stable(drive_reduce))
    else $error("drive reduce rewritten");
endmodule
bind gpk_ports gpk_ports_sva chk (.clk, .rst_n, .op_mode, .addr, .wdata, .wr, .rd, .rdata,
  .pa_oe_n, .pb_oe_n, .pe_oe_n, .pg_oe_n, .ph_oe_n, .pa_pullup, .pb_pullup, .pe_pullup,
  .pg_pullup, .pg_pulldown, .pe_assign, .drive_reduce);

// ===== sim/gpk_ports_test.sv
`timescale 1ns/100ps
`include "gpk_map.vh"
module gpk_ports_test;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
  logic port_e_emulation_select = 1'b0;
  logic port_g_pull_polarity_pin = 1'b0, port_h_pull_polarity_pin = 1'b0;
  logic [1:0] op_mode = 2'h0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, d, v, r;
  logic [7:0] ext [5] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
  logic [15:0] seed = 16'd5815, ent;
  logic [15:0] exq [$];
  int n_mismatch = 0, checked = 0;
  wire [7:0] rdata, pa_in, pb_in, pe_in, pg_in, ph_in, pa_out, pb_out, pe_out, pg_out, ph_out;
  wire [7:0] pa_oe_n, pb_oe_n, pe_oe_n, pg_oe_n, ph_oe_n, pa_pullup, pb_pullup, pe_pullup;
  wire [7:0] pg_pullup, pg_pulldown, ph_pullup, ph_pulldown, pe_assign, drive_reduce;
  wire port_g_wake_irq, port_h_wake_irq, maskable_irq_pin, nonmaskable_irq_input;
  wire [39:0] oen = {ph_oe_n, pg_oe_n, pe_oe_n, pb_oe_n, pa_oe_n};
  wire [39:0] pu = {ph_pullup, pg_pullup, pe_pullup, pb_pullup, pa_pullup};
  wire [39:0] pd = {ph_pulldown, pg_pulldown, 24'h000000};
  wire [39:0] po = {ph_out, pg_out, pe_out, pb_out, pa_out};
  logic [7:0] dirs [4] = '{`GPK_A_DIR, `GPK_B_DIR, `GPK_G_DIR, `GPK_H_DIR};
  logic [7:0] dats [4] = '{`GPK_A_DATA, `GPK_B_DATA, `GPK_G_DATA, `GPK_H_DATA};
  int px [4] = '{0, 8, 24, 32};
  always #4 clk = ~clk;
  gpk_ports dut (.clk, .rst_n, .op_mode, .port_e_emulation_select, .addr, .wdata, .wr, .rd,
    .rdata, .pa_in, .pa_out, .pa_oe_n, .pa_pullup, .pb_in, .pb_out, .pb_oe_n, .pb_pullup,
    .pe_in, .pe_out, .pe_oe_n, .pe_pullup, .pe_assign, .pg_in, .pg_out, .pg_oe_n, .pg_pullup,
    .pg_pulldown, .port_g_pull_polarity_pin, .ph_in, .ph_out, .ph_oe_n, .ph_pullup,
    .ph_pulldown, .port_h_pull_polarity_pin, .drive_reduce, .port_g_wake_irq,
    .port_h_wake_irq, .maskable_irq_pin, .nonmaskable_irq_input);
  gpk_pins pa_m (.out(pa_out), .oe_n(pa_oe_n), .ext(ext[0]), .pin(pa_in));
  gpk_pins pb_m (.out(pb_out), .oe_n(pb_oe_n), .ext(ext[1]), .pin(pb_in));
  gpk_pins pe_m (.out(pe_out), .oe_n(pe_oe_n), .ext(ext[2]), .pin(pe_in));
  gpk_pins pg_m (.out(pg_out), .oe_n(pg_oe_n), .ext(ext[3]), .pin(pg_in));
  gpk_pins ph_m (.out(ph_out), .oe_n(ph_oe_n), .ext(ext[4]), .pin(ph_in));
  function logic [7:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed[7:0];
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
    checked++;
    if ((got & m) !== (exp & m)) begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] w);
    addr <= a;
    wdata <= w;
    wr <= 1'b1;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    exq.push_back({m, e});
    addr <= a;
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
  endtask
  task automatic end_sim();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    rd_d <= rd;
    if (rd_d) begin
      ent = exq.pop_front();
      chk(rdata, ent[7:0], ent[15:8]);
    end
  end
  initial begin
    #40000;
    n_mismatch++;
    end_sim();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(pa_oe_n & pb_oe_n & pe_oe_n & pg_oe_n & ph_oe_n, 8'hff, 8'hff);
    rreg(`GPK_A_DIR, 8'h00, 8'hff);
    wreg(`GPK_PULL_CTL, 8'h73);
    for (int p = 0; p < 2; p++) begin
      port_g_pull_polarity_pin <= p[0];
      port_h_pull_polarity_pin <= p[0];
      foreach (dirs[i]) begin
        d = rnd();
        v = rnd();
        wreg(dats[i], v);
        wreg(dirs[i], d);
        cyc(3);
        chk(oen[px[i] +: 8], ~d, 8'hff);
        chk(po[px[i] +: 8], v, d);
        chk(pu[px[i] +: 8], (i < 2 || p == 1) ? ~d : 8'h00, 8'hff);
        chk(pd[px[i] +: 8], (i > 1 && p == 0) ? ~d : 8'h00, 8'hff);
        rreg(dirs[i], d, 8'hff);
        rreg(dats[i], v | ~d, 8'hff);
      end
    end
    $display("direction test done");
    r = rnd();
    ext[2] <= r;
    wreg(`GPK_E_DIR, 8'hff);
    wreg(`GPK_E_ASSIGN, 8'h0c);
    wreg(`GPK_E_DATA, r);
    cyc(3);
    chk(pe_oe_n, 8'h0f, 8'hff);
    chk(pe_out, r, 8'hf0);
    chk({7'h00, maskable_irq_pin}, {7'h00, r[1]}, 8'hff);
    chk(pe_pullup, 8'h0f, 8'hff);
    chk(pe_assign, 8'h0c, 8'hff);
    chk({7'h00, nonmaskable_irq_input}, {7'h00, r[0]}, 8'hff);
    rreg(`GPK_E_DATA, r, 8'hff);
    r = rnd() & 8'h73;
    wreg(`GPK_DRIVE_CTL, r);
    wreg(`GPK_DRIVE_CTL, ~r);
    cyc(3);
    chk(drive_reduce, r, 8'hff);
    $display("port e test done");
    wreg(`GPK_G_DIR, 8'h00);
    wreg(`GPK_H_DIR, 8'h00);
    wreg(`GPK_G_WIE, 8'h01);
    wreg(`GPK_H_WIE, 8'h00);
    cyc(5);
    wreg(`GPK_G_WFLG, 8'hff);
    wreg(`GPK_H_WFLG, 8'hff);
    ext[3] <= 8'hfe;
    ext[4] <= 8'hfe;
    cyc(6);
    chk({6'h00, port_h_wake_irq, port_g_wake_irq}, 8'h01, 8'hff);
    rreg(`GPK_G_WFLG, 8'h01, 8'hff);
    rreg(`GPK_H_WFLG, 8'h01, 8'hff);
    rreg(`GPK_H_DATA, 8'hfe, 8'hff);
    wreg(`GPK_G_WFLG, 8'h01);
    cyc(3);
    chk({7'h00, port_g_wake_irq}, 8'h00, 8'hff);
    rreg(`GPK_G_WFLG, 8'h00, 8'hff);
    $display("wake test done");
    op_mode <= `GPK_MODE_PERIPH;
    cyc(3);
    wreg(`GPK_A_DIR, 8'haa);
    rreg(`GPK_A_DIR, 8'h00, 8'hff);
    rreg(`GPK_E_DIR, 8'h00, 8'hff);
    rreg(`GPK_DRIVE_CTL, 8'h00, 8'hff);
    rreg(8'hff, 8'h00, 8'hff);
    op_mode <= `GPK_MODE_EXPANDED;
    port_e_emulation_select <= 1'b1;
    cyc(4);
    chk(pa_pullup | pb_pullup, 8'h00, 8'hff);
    rreg(`GPK_B_DIR, 8'h00, 8'hff);
    rreg(`GPK_E_DIR, 8'h00, 8'hff);
    port_e_emulation_select <= 1'b0;
    cyc(2);
    rreg(`GPK_E_DIR, 8'hff, 8'hfc);
    cyc(2);
    $display("mode test done");
    end_sim();
  end
endmodule
